// ===== rtl/mgmt_mem_pkg.sv
package mgmt_mem_pkg;
  localparam logic [6:0] DEV_ADDR         = 7'h50;
  localparam logic [7:0] OFS_TYPE_ID      = 8'h00;
  localparam logic [7:0] OFS_STATUS       = 8'h02;
  localparam logic [7:0] OFS_RX_LOSS      = 8'h03;
  localparam logic [7:0] OFS_TX_FAULT     = 8'h04;
  localparam logic [7:0] OFS_TEMP_FLAGS   = 8'h06;
  localparam logic [7:0] OFS_SUPPLY_FLAGS = 8'h07;
  localparam logic [7:0] OFS_RXP_12       = 8'h09;
  localparam logic [7:0] OFS_RXP_34       = 8'h0A;
  localparam logic [7:0] OFS_TXB_12       = 8'h0B;
  localparam logic [7:0] OFS_RW_FIRST     = 8'h56;
  localparam logic [7:0] OFS_PAGE_SEL     = 8'h7F;
  localparam logic [7:0] OFS_UPPER_ID     = 8'h80;
  localparam int         STATUS_FLAT_BIT  = 2;
  localparam int         STATUS_INT_BIT   = 1;
  localparam int         STATUS_DNR_BIT   = 0;
  localparam int         WRITE_BURST_MAX  = 4;
  localparam int         CLK_HZ           = 100_000_000;
  localparam int         T_WR_MS          = 40;
  localparam int         T_INT_OFF_US     = 500;
  localparam int         WR_CYCLES        = CLK_HZ / 1000 * T_WR_MS;
  localparam int         INT_OFF_CYCLES   = CLK_HZ / 1_000_000 * T_INT_OFF_US;
  localparam logic [7:0] PAGE_00          = 8'h00;
  localparam logic [7:0] PAGE_02          = 8'h02;
  localparam logic [7:0] PAGE_03          = 8'h03;

  typedef struct packed {
    logic [3:0] rx_loss;
    logic [3:0] tx_fault;
    logic [3:0] temp;
    logic [3:0] supply;
    logic [15:0] rx_power;
    logic [7:0]  tx_bias_12;
  } flag_events_t;
endpackage : mgmt_mem_pkg

// ===== rtl/module_mgmt_two_wire_memory.sv
`timescale 1ns/1ns
// Functional notes
// (R1) Acked reads keep sending successive bytes
// (R2) Host ends reads with NACK, STOP
// (R3) Byte write: address, offset, data, acks
// (R4) Write commits only on closing STOP
// (R5) Repeated START aborts write, discards data
// (R6) Busy write cycle ignores bus entirely
// (R7) Host uses no combined format writes
// (R8) Up to four sequential data bytes
// (R9) Ack every received write data byte; code NACKs data bytes after the fourth
// (R10) Write without STOP is discarded
// (R11) Lower 128 bytes plus paged upper
// (R12) Pages 00, 02, 03 present, 01 absent
// (R13) Byte 127 selects upper page
// (R14) Bytes 0-85 read-only, 86-126 writable
// (R15) Byte 0 equals upper byte 128
// (R16) Status bit 2 reads paged; code returns 1 (STATUS_FLAT_BIT, flat)
// (R17) Status bit 1 mirrors interrupt pin
// (R18) Status bit 0 high until monitors valid
// (R19) Flags latch set on condition
// (R20) Bytes 3, 4 per-channel LOS, fault
// (R21) Bytes 6, 7 temperature, supply flags
// (R22) Bytes 9-11 rx power, tx bias flags
// (R23) Write cycle ends within 40 ms
// (R24) Respond only while select is low
// (R25) Device address 1010000 plus R/W
// (R26) Read clears flag; release interrupt
// (R27) Foreign address not acknowledged
// (R28) Pointer increments after each byte
module module_mgmt_two_wire_memory
  import mgmt_mem_pkg::*;
#(
  parameter int         WR_TIME   = WR_CYCLES,
  parameter int         INT_TIME  = INT_OFF_CYCLES,
  parameter logic [7:0] TYPE_CODE = 8'h5A  // Arbitrary identifier value
) (
  input  wire logic         mclk,
  input  wire logic         arst_n,
  input  wire logic         clk_en,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output logic              sda_out,
  output logic              sda_oe_n,
  input  wire logic         module_select_n,
  input  wire flag_events_t flag_events,
  input  wire logic         monitors_valid,
  output logic              interrupt_out_n
);
  initial begin
    if (WR_TIME < 1 || INT_TIME < 1) $error("Timing counts must be positive");
  end

  typedef enum {IDLE, ADDR, ADDR_ACK, OFFS, OFFS_ACK, WDATA, WDATA_ACK,
                RDATA, RDATA_ACK, SKIP, BUSY} state_t;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and bus edge detection
  logic [1:0] scl_s, sda_s, sel_s;
  logic       scl_d, sda_d;
  logic       scl_rise, scl_fall, start_ev, stop_ev, selected;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      sel_s <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en) begin
      scl_s <= {scl_s[0], scl_in};
      sda_s <= {sda_s[0], sda_in};
      sel_s <= {sel_s[0], module_select_n};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end
  assign selected = !sel_s[1];                                       // see (R24)
  assign scl_rise = scl_s[1] && !scl_d;
  assign scl_fall = !scl_s[1] && scl_d;
  assign start_ev = scl_s[1] && scl_d && sda_d && !sda_s[1];
  assign stop_ev  = scl_s[1] && scl_d && !sda_d && sda_s[1];

  ////////////////////////////////////////////////////////////////////////
  // Memory arrays
  logic [7:0] rw_lower [86:126];
  logic [7:0] page_sel;
  logic [7:0] upper    [0:2][0:127];
  logic [3:0] rx_loss, tx_fault, temp_fl, supply_fl;
  logic [15:0] rxp_fl;
  logic [7:0] txb_fl;
  logic       not_ready;

  function automatic logic [1:0] page_index(input logic [7:0] p);
    page_index = (p == PAGE_02) ? 2'd1 : (p == PAGE_03) ? 2'd2 : 2'd0;
  endfunction : page_index

  function automatic logic page_present(input logic [7:0] p);
    page_present = (p == PAGE_00) || (p == PAGE_02) || (p == PAGE_03); // see (R12)
  endfunction : page_present

  function automatic logic [7:0] read_byte(input logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[7]) begin                                                  // see (R11) (R13)
      if (a == OFS_UPPER_ID && page_sel == PAGE_00) v = TYPE_CODE;
      else if (page_present(page_sel)) v = upper[page_index(page_sel)][a[6:0]];
    end else begin
      case (a)
        OFS_TYPE_ID:      v = TYPE_CODE;                             // see (R15)
        OFS_STATUS:       v = {5'h00, 1'b1, interrupt_out_n, not_ready}; // see (R16) (R17)
        OFS_RX_LOSS:      v = {4'h0, rx_loss};                       // see (R20)
        OFS_TX_FAULT:     v = {4'h0, tx_fault};
        OFS_TEMP_FLAGS:   v = {temp_fl, 4'h0};                       // see (R21)
        OFS_SUPPLY_FLAGS: v = {supply_fl, 4'h0};
        OFS_RXP_12:       v = rxp_fl[15:8];                          // see (R22)
        OFS_RXP_34:       v = rxp_fl[7:0];
        OFS_TXB_12:       v = txb_fl;
        OFS_PAGE_SEL:     v = page_sel;
        default:          v = (a >= OFS_RW_FIRST) ? rw_lower[a] : 8'h00;
      endcase
    end
    read_byte = v;
  endfunction : read_byte

  ////////////////////////////////////////////////////////////////////////
  // Serial engine
  state_t      state, next_state;
  logic [7:0]  shreg, next_shreg, ptr, next_ptr;
  logic [3:0]  bitcnt, next_bitcnt;
  logic        rd_mode, next_rd_mode;
  logic [7:0]  wbuf [0:3];
  logic [7:0]  next_wbuf [0:3];
  logic [2:0]  wcount, next_wcount;
  logic [7:0]  wbase, next_wbase;
  logic [31:0] busy_cnt, next_busy_cnt;
  logic        commit, clear_rd;
  logic [7:0]  clear_addr;
  logic        next_sda_out, next_sda_oe_n;

  always_comb begin
    next_state    = state;
    next_shreg    = shreg;
    next_ptr      = ptr;
    next_bitcnt   = bitcnt;
    next_rd_mode  = rd_mode;
    next_wbuf     = wbuf;
    next_wcount   = wcount;
    next_wbase    = wbase;
    next_busy_cnt = busy_cnt;
    next_sda_out  = sda_out;
    next_sda_oe_n = sda_oe_n;
    commit        = 1'b0;
    clear_rd      = 1'b0;
    clear_addr    = ptr;
    if (state == BUSY) begin                                         // see (R6)
      next_sda_oe_n = 1'b1;
      if (busy_cnt >= 32'(WR_TIME - 1)) next_state = IDLE;           // see (R23)
      else next_busy_cnt = busy_cnt + 32'd1;
    end else if (!selected) begin                                    // see (R24)
      next_state    = IDLE;
      next_sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      next_sda_oe_n = 1'b1;
      if ((state == WDATA || state == WDATA_ACK) && wcount != 3'd0) begin
        commit        = 1'b1;                                        // see (R4)
        next_state    = BUSY;
        next_busy_cnt = 32'd0;
      end else next_state = IDLE;
    end else if (start_ev) begin
      next_state    = ADDR;                                          // see (R5) (R10)
      next_wcount   = 3'd0;
      next_bitcnt   = 4'd0;
      next_sda_oe_n = 1'b1;
    end else begin
      case (state)
        ADDR, OFFS, WDATA: begin
          if (scl_rise) begin
            next_shreg  = {shreg[6:0], sda_s[1]};
            next_bitcnt = bitcnt + 4'd1;
          end else if (scl_fall && bitcnt == 4'd8) begin
            next_bitcnt = 4'd0;
            if (state == ADDR) begin
              if (shreg[7:1] == DEV_ADDR) begin                      // see (R25)
                next_rd_mode  = shreg[0];
                next_state    = ADDR_ACK;
                next_sda_out  = 1'b0;
                next_sda_oe_n = 1'b0;
              end else next_state = SKIP;                            // see (R27)
            end else if (state == OFFS) begin
              next_ptr      = shreg;                                 // see (R3)
              next_wbase    = shreg;
              next_state    = OFFS_ACK;
              next_sda_out  = 1'b0;
              next_sda_oe_n = 1'b0;
            end else if (wcount < 3'(WRITE_BURST_MAX)) begin         // see (R8)
              next_wbuf[wcount[1:0]] = shreg;
              next_wcount   = wcount + 3'd1;
              next_ptr      = ptr + 8'd1;                            // see (R28)
              next_state    = WDATA_ACK;
              next_sda_out  = 1'b0;                                  // see (R9)
              next_sda_oe_n = 1'b0;
            end else next_state = WDATA;                             // see (R8)
          end
        end
        ADDR_ACK, OFFS_ACK, WDATA_ACK: begin
          if (scl_fall) begin
            next_sda_oe_n = 1'b1;
            if (state == ADDR_ACK && rd_mode) begin
              next_shreg    = read_byte(ptr);                        // see (R1)
              clear_rd      = 1'b1;
              next_ptr      = ptr + 8'd1;                            // see (R28)
              next_sda_out  = next_shreg[7];
              next_sda_oe_n = 1'b0;
              next_bitcnt   = 4'd1;
              next_state    = RDATA;
            end else begin
              next_state = (state == ADDR_ACK) ? OFFS : WDATA;
            end
          end
        end
        RDATA: begin
          if (scl_fall) begin
            if (bitcnt == 4'd8) begin
              next_sda_oe_n = 1'b1;
              next_state    = RDATA_ACK;
            end else begin
              next_sda_out = shreg[3'(7 - bitcnt)];
              next_bitcnt  = bitcnt + 4'd1;
            end
          end
        end
        RDATA_ACK: begin
          if (scl_rise) begin
            next_state = sda_s[1] ? SKIP : RDATA_ACK;                // see (R2)
          end else if (scl_fall) begin
            next_shreg    = read_byte(ptr);                          // see (R1)
            clear_rd      = 1'b1;
            next_ptr      = ptr + 8'd1;
            next_sda_out  = next_shreg[7];
            next_sda_oe_n = 1'b0;
            next_bitcnt   = 4'd1;
            next_state    = RDATA;
          end
        end
        SKIP, IDLE: next_sda_oe_n = 1'b1;
        default: next_state = IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state    <= IDLE;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      bitcnt   <= 4'h0;
      rd_mode  <= 1'b0;
      wcount   <= 3'h0;
      wbase    <= 8'h00;
      busy_cnt <= 32'h0;
      sda_out  <= 1'b1;
      sda_oe_n <= 1'b1;
      for (int i = 0; i < 4; i++) wbuf[i] <= 8'h00;
    end else if (clk_en) begin
      state    <= next_state;
      shreg    <= next_shreg;
      ptr      <= next_ptr;
      bitcnt   <= next_bitcnt;
      rd_mode  <= next_rd_mode;
      wcount   <= next_wcount;
      wbase    <= next_wbase;
      busy_cnt <= next_busy_cnt;
      sda_out  <= next_sda_out;
      sda_oe_n <= next_sda_oe_n;
      wbuf     <= next_wbuf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory commit, flags and interrupt
  logic [7:0] cur_page;
  assign cur_page = page_sel;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      page_sel <= 8'h00;
      for (int i = 86; i <= 126; i++) rw_lower[i] <= 8'h00;
      for (int p = 0; p < 3; p++)
        for (int j = 0; j < 128; j++) upper[p][j] <= 8'h00;
    end else if (clk_en && commit) begin
      for (int k = 0; k < WRITE_BURST_MAX; k++) begin
        if (3'(k) < wcount) begin
          logic [7:0] a;
          a = wbase + 8'(k);
          if (a == OFS_PAGE_SEL) page_sel <= wbuf[k];                // see (R13)
          else if (a[7]) begin
            if (page_present(cur_page))
              upper[page_index(cur_page)][a[6:0]] <= wbuf[k];
          end else if (a >= OFS_RW_FIRST) rw_lower[a] <= wbuf[k];    // see (R14)
        end
      end
    end
  end

  function automatic logic hit(input logic c, input logic [7:0] a, input logic [7:0] o);
    hit = c && (a == o);                                             // see (R26)
  endfunction : hit

  logic [31:0] int_cnt;
  logic        any_flag;
  assign any_flag = |{rx_loss, tx_fault, temp_fl, supply_fl, rxp_fl, txb_fl};
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_loss         <= 4'h0;
      tx_fault        <= 4'h0;
      temp_fl         <= 4'h0;
      supply_fl       <= 4'h0;
      rxp_fl          <= 16'h0000;
      txb_fl          <= 8'h00;
      not_ready       <= 1'b1;
      int_cnt         <= 32'h0;
      interrupt_out_n <= 1'b1;
    end else if (clk_en) begin
      // Set wins over clear-on-read; see (R19)
      rx_loss   <= (hit(clear_rd, clear_addr, OFS_RX_LOSS) ? 4'h0 : rx_loss)
                   | flag_events.rx_loss;
      tx_fault  <= (hit(clear_rd, clear_addr, OFS_TX_FAULT) ? 4'h0 : tx_fault)
                   | flag_events.tx_fault;
      temp_fl   <= (hit(clear_rd, clear_addr, OFS_TEMP_FLAGS) ? 4'h0 : temp_fl)
                   | flag_events.temp;
      supply_fl <= (hit(clear_rd, clear_addr, OFS_SUPPLY_FLAGS) ? 4'h0 : supply_fl)
                   | flag_events.supply;
      rxp_fl[15:8] <= (hit(clear_rd, clear_addr, OFS_RXP_12) ? 8'h00 : rxp_fl[15:8])
                      | flag_events.rx_power[15:8];
      rxp_fl[7:0]  <= (hit(clear_rd, clear_addr, OFS_RXP_34) ? 8'h00 : rxp_fl[7:0])
                      | flag_events.rx_power[7:0];
      txb_fl    <= (hit(clear_rd, clear_addr, OFS_TXB_12) ? 8'h00 : txb_fl)
                   | flag_events.tx_bias_12;
      if (monitors_valid) not_ready <= 1'b0;                         // see (R18)
      if (any_flag) begin
        int_cnt         <= 32'h0;
        interrupt_out_n <= 1'b0;
      end else if (!interrupt_out_n) begin
        if (int_cnt >= 32'(INT_TIME - 1)) interrupt_out_n <= 1'b1;   // see (R26)
        else int_cnt <= int_cnt + 32'd1;
      end
    end
  end
endmodule : module_mgmt_two_wire_memory

// ===== tb/mgmt_mem_asserts.sv
`timescale 1ns/1ns
module mgmt_mem_asserts
  import mgmt_mem_pkg::*;
#(
  parameter int INT_TIME = 20
) (
  input wire logic         mclk,
  input wire logic         arst_n,
  input wire logic         clk_en,
  input wire logic         scl_in,
  input wire logic         sda_out,
  input wire logic         sda_oe_n,
  input wire logic         module_select_n,
  input wire flag_events_t flag_events,
  input wire logic         interrupt_out_n
);
  logic [15:0] quiet;
  logic [15:0] next_quiet;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  // Cycles since last flag event
  always_comb begin
    next_quiet = quiet;
    if (|flag_events) next_quiet = '0;
    else if (clk_en && quiet != 16'hFFFF) next_quiet = quiet + 16'h0001;
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) quiet <= '0;
    else quiet <= next_quiet;
  end
  ////////////////////////////////////////////////////////////
  sequence s_desel;
    module_select_n [*6];
  endsequence
  sequence s_event;
    clk_en && (|flag_events);
  endsequence
  a_reset_quiet: assert property ($rose(arst_n) |-> sda_oe_n && interrupt_out_n)
    else $error("bus or interrupt active after reset");
  a_desel_release: assert property (s_desel |-> sda_oe_n)
    else $error("bus driven while deselected");
  a_drive_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
    else $error("data line taken while clock high");
  a_release_scl_low: assert property ($rose(sda_oe_n) && !module_select_n
    && !$past(module_select_n, 4) |-> !scl_in)
    else $error("data line released while clock high");
  a_data_stable: assert property (!sda_oe_n && scl_in && $past(scl_in) |-> $stable(sda_out))
    else $error("driven data changed while clock high");
  a_event_int: assert property (s_event |-> ##[1:4] !interrupt_out_n)
    else $error("flag event did not assert interrupt");
  a_int_hold: assert property ((s_event and !interrupt_out_n) |=> !interrupt_out_n)
    else $error("interrupt released during event");
  a_int_release: assert property ($rose(interrupt_out_n) |-> quiet + 16'h0002 >= INT_TIME)
    else $error("interrupt released too early");
endmodule : mgmt_mem_asserts

bind module_mgmt_two_wire_memory mgmt_mem_asserts #(.INT_TIME(INT_TIME)) u_asserts (
  .mclk(mclk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .module_select_n(module_select_n),
  .flag_events(flag_events),
  .interrupt_out_n(interrupt_out_n)
);

// ===== tb/host_master.sv
`timescale 1ns/1ns
module host_master #(
  parameter int QTR = 4
) (
  input  wire logic mclk,
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  output logic      scl,
  output logic      sda
);
  logic host_sda;
  // Open-drain wire with pull-up
  assign sda = host_sda & (sda_oe_n | sda_out);
  initial begin
    scl = 1'b1;
    host_sda = 1'b1;
  end
  task automatic q;
    repeat (QTR) @(negedge mclk);
  endtask : q
  task automatic start;
    q();
    q();
    host_sda = 1'b1;
    q();
    scl = 1'b1;
    q();
    host_sda = 1'b0;
    q();
    scl = 1'b0;
  endtask : start
  task automatic stop;
    q();
    host_sda = 1'b0;
    q();
    scl = 1'b1;
    q();
    host_sda = 1'b1;
    q();
  endtask : stop
  task automatic bit_io(input logic b, output logic s);
    q();
    host_sda = b;
    q();
    scl = 1'b1;
    q();
    s = sda;
    q();
    scl = 1'b0;
  endtask : bit_io
  // Byte MSB first, then ack bit
  task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r[i]);
    end
    bit_io(ack_in, ack);
  endtask : xfer
endmodule : host_master

// ===== tb/test_module_mgmt_two_wire_memory.sv
`timescale 1ns/1ns
module test_module_mgmt_two_wire_memory
  import mgmt_mem_pkg::*;
;
  localparam int         WRT = 50;
  localparam int         INTT = 20;
  localparam logic [7:0] TID = 8'h5A;  // Arbitrary identifier value
  localparam logic [7:0] FEXP [10] = '{8'h04, 8'h05, 8'h0A, 8'h00, 8'hC0, 8'h30, 8'h00,
                                       8'h80, 8'h01, 8'h81};
  logic         mclk;
  logic         arst_n;
  logic         module_select_n;
  logic         monitors_valid;
  flag_events_t flag_events;
  logic         sda_out;
  logic         sda_oe_n;
  logic         interrupt_out_n;
  logic         scl;
  logic         sda;
  logic [7:0]   got [10];
  int           num_errors = 0;
  int           samples_checked = 0;
  module_mgmt_two_wire_memory #(.WR_TIME(WRT), .INT_TIME(INTT), .TYPE_CODE(TID)) dut (
    .mclk(mclk), .arst_n(arst_n), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .module_select_n(module_select_n),
    .flag_events(flag_events), .monitors_valid(monitors_valid),
    .interrupt_out_n(interrupt_out_n));
  host_master host (.mclk(mclk), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl(scl),
    .sda(sda));
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic ack_is(input logic a, input logic exp);
    check("ack", {7'h00, a}, {7'h00, exp});
  endtask : ack_is
  task automatic wr(input logic [7:0] ofs, input logic [39:0] d, input int n,
                    input logic abort);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer(8'hA0, 1'b1, r, a);
    ack_is(a, 1'b0);
    host.xfer(ofs, 1'b1, r, a);
    ack_is(a, 1'b0);
    for (int i = 0; i < n; i++) begin
      host.xfer(d[39 - 8 * i -: 8], 1'b1, r, a);
      ack_is(a, i >= 4);
    end
    if (abort) host.start();
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ofs, input int n, input logic rand_rd);
    logic [7:0] r;
    logic       a;
    host.start();
    if (rand_rd) begin
      host.xfer(8'hA0, 1'b1, r, a);
      host.xfer(ofs, 1'b1, r, a);
      host.start();
    end
    host.xfer(8'hA1, 1'b1, r, a);
    ack_is(a, 1'b0);
    for (int i = 0; i < n; i++) host.xfer(8'hFF, i == n - 1, got[i], a);
    host.stop();
  endtask : rd
  task automatic probe(input logic [7:0] adr);
    logic [7:0] r;
    logic       a;
    host.start();
    host.xfer(adr, 1'b1, r, a);
    ack_is(a, 1'b1);
    host.stop();
  endtask : probe
  task automatic settle;
    repeat (WRT + 20) @(negedge mclk);
  endtask : settle
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    end_of_test();
  end
  initial begin
    arst_n = 1'b0;
    module_select_n = 1'b0;
    monitors_valid = 1'b0;
    flag_events = '0;
    repeat (4) @(negedge mclk);
    arst_n = 1'b1;
    repeat (4) @(negedge mclk);
    rd(8'h00, 3, 1'b1);
    check("type id", got[0], TID);
    check("status", got[2], 8'h07);
    $display("test map after reset done");
    monitors_valid = 1'b1;
    flag_events = {4'h5, 4'hA, 4'hC, 4'h3, 16'h8001, 8'h81};
    @(negedge mclk);
    flag_events = '0;
    repeat (4) @(negedge mclk);
    check("int pin", {7'h00, interrupt_out_n}, 8'h00);
    rd(8'h02, 10, 1'b1);
    foreach (got[i]) check("flags", got[i], FEXP[i]);
    rd(8'h02, 10, 1'b1);
    foreach (got[i]) check("cleared", got[i], (i == 0) ? 8'h06 : 8'h00);
    check("int pin", {7'h00, interrupt_out_n}, 8'h01);
    $display("test flags done");
    wr(8'h56, 40'h1122334455, 5, 1'b0);
    probe(8'hA0);
    settle();
    rd(8'h56, 2, 1'b1);
    check("seq 0", got[0], 8'h11);
    check("seq 1", got[1], 8'h22);
    rd(8'h00, 1, 1'b0);
    check("current", got[0], 8'h33);
    rd(8'h59, 1, 1'b1);
    check("seq 3", got[0], 8'h44);
    wr(8'h00, 40'hFF00000000, 1, 1'b0);
    settle();
    rd(8'h00, 1, 1'b1);
    check("ro byte", got[0], TID);
    wr(8'h60, 40'h1200000000, 1, 1'b0);
    settle();
    wr(8'h60, 40'h9900000000, 1, 1'b1);
    settle();
    rd(8'h60, 1, 1'b1);
    check("aborted", got[0], 8'h12);
    $display("test writes done");
    probe(8'hA4);
    module_select_n = 1'b1;
    repeat (8) @(negedge mclk);
    probe(8'hA1);
    module_select_n = 1'b0;
    repeat (8) @(negedge mclk);
    wr(8'h7F, 40'h0300000000, 1, 1'b0);
    settle();
    rd(8'h7F, 1, 1'b1);
    check("page sel", got[0], 8'h03);
    wr(8'h7F, 40'h0000000000, 1, 1'b0);
    settle();
    rd(8'h80, 1, 1'b1);
    check("upper id", got[0], TID);
    $display("test select and pages done");
    end_of_test();
  end
endmodule : test_module_mgmt_two_wire_memory
